// >>> hw/arps_pkg.sv
package arps_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses on the avalon slave)
    // ------------------------------------------------------------
    localparam int ADDR_W = 7;
    localparam logic [6:0] CTRL1_OFS = 7'h00;
    localparam logic [6:0] CTRL2_OFS = 7'h04;
    localparam logic [6:0] CTRL3_OFS = 7'h08;
    localparam logic [6:0] MUX_OFS = 7'h0c;
    localparam logic [6:0] STAT_OFS = 7'h10;
    localparam logic [6:0] BUF_OFS = 7'h40;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ON_BIT = 15;
    localparam int TRIG_LSB = 5;
    localparam int SIMUL_BIT = 3;
    localparam int AUTO_BIT = 2;
    localparam int SHC_BIT = 1;
    localparam int DONE_BIT = 0;
    localparam int CHCNT_LSB = 8;
    localparam int CPI_LSB = 2;
    localparam int ASC_LSB = 8;
    localparam int RC_BIT = 7;
    localparam int DIV_LSB = 0;
    localparam int IRQ_BIT = 0;
    localparam int POWER_BIT = 1;
    localparam int BUSY_BIT = 2;
    localparam int OFF_BIT = 3;

    // ------------------------------------------------------------
    // encodings and timing
    // ------------------------------------------------------------
    localparam logic [2:0] TRIG_MANUAL = 3'h0;
    localparam logic [2:0] TRIG_AUTO = 3'h7;
    localparam int CONV_TADS = 12;
    localparam int MIN_SAMPLE_TADS = 1;
    localparam int CORE_NS = 20;
    localparam int TCY_NS = 40;
    localparam int INSTR_CLKS = (TCY_NS + CORE_NS - 1) / CORE_NS;
    localparam int RESULT_W = 10;
    localparam int BUF_DEPTH = 16;

    typedef enum logic [1:0] {
        ARPS_IDLE,
        ARPS_SAMPLE,
        ARPS_CONVERT
    } arps_phase_type;

endpackage : arps_pkg

// >>> hw/arps_sequencer.sv
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
module arps_sequencer #(
    parameter int DATA_W = arps_pkg::RESULT_W
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // avalon-mm slave
    input wire logic [arps_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // device and cpu side
    input wire logic sleep_mode,
    input wire logic int_enable,
    input wire logic ext_trigger,
    output logic wake_req,
    output logic conv_irq,
    // analog side
    input wire logic rc_osc,
    input wire logic [DATA_W-1:0] adc_data,
    output logic [3:0] sh_sample,
    output logic conv_start,
    output logic analog_power
);
    import arps_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic waitreq;
        logic [31:0] rdata;
        logic converter_on;
        logic [2:0] trigger_source_select;
        logic simultaneous_sample_select;
        logic auto_sample_enable;
        logic sample_hold_control;
        logic done;
        logic [1:0] sh_channel_count;
        logic [3:0] conversions_per_interrupt;
        logic [4:0] auto_sample_clocks;
        logic rc_clock_select;
        logic [5:0] conv_clock_divider;
        logic [15:0] input_mux_select;
        arps_phase_type phase;
        logic [4:0] sample_tads;
        logic [3:0] conv_tads;
        logic [5:0] tad_cnt;
        logic [1:0] chan;
        logic [3:0] hold;
        logic trig_pend;
        logic [3:0] wr_idx;
        logic [3:0] conv_cnt;
        logic [BUF_DEPTH-1:0][DATA_W-1:0] result_buffer;
        logic [DATA_W-1:0] data_s1;
        logic [DATA_W-1:0] data_s2;
        logic [2:0] rc_s;
        logic sleep_d;
        logic [1:0] rc_wait;
        logic off;
        logic irq_flag;
        logic wake;
        logic irq;
        logic start;
        logic [3:0] sample_out;
        logic power;
    } arps_state_type;

    arps_state_type s_q;
    arps_state_type s_d;
    logic tad_tick;
    logic conv_trig;
    logic conv_end;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] arps_merge(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old & ~m) | (wd & m);
    endfunction : arps_merge

    function automatic logic [1:0] arps_last(input logic [1:0] cnt);
        return (cnt == 2'h0) ? 2'h0 : ((cnt == 2'h1) ? 2'h1 : 2'h3);
    endfunction : arps_last

    function automatic logic [3:0] arps_mask(input logic [1:0] cnt);
        return (cnt == 2'h0) ? 4'h1 : ((cnt == 2'h1) ? 4'h3 : 4'hf);
    endfunction : arps_mask

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] c1;
        logic [31:0] c2;
        logic [31:0] c3;
        logic [31:0] st;
        logic [31:0] w;
        logic [31:0] rd;
        logic wcommit;
        logic active;
        logic [4:0] samc_eff;
        logic [1:0] last;
        s_d = s_q;
        c1 = REG_RESET;
        c2 = REG_RESET;
        c3 = REG_RESET;
        st = REG_RESET;
        rd = REG_RESET;
        c1[ON_BIT] = s_q.converter_on;
        c1[TRIG_LSB+:3] = s_q.trigger_source_select;
        c1[SIMUL_BIT] = s_q.simultaneous_sample_select;
        c1[AUTO_BIT] = s_q.auto_sample_enable;
        c1[SHC_BIT] = s_q.sample_hold_control;
        c1[DONE_BIT] = s_q.done;
        c2[CHCNT_LSB+:2] = s_q.sh_channel_count;
        c2[CPI_LSB+:4] = s_q.conversions_per_interrupt;
        c3[ASC_LSB+:5] = s_q.auto_sample_clocks;
        c3[RC_BIT] = s_q.rc_clock_select;
        c3[DIV_LSB+:6] = s_q.conv_clock_divider;
        st[IRQ_BIT] = s_q.irq_flag;
        st[POWER_BIT] = s_q.power;
        st[BUSY_BIT] = (s_q.phase == ARPS_CONVERT);
        st[OFF_BIT] = s_q.off;

        // bus: ack one cycle after the request, read data lands on that edge, write one edge later
        s_d.waitreq = !((avs_read || avs_write) && s_q.waitreq);
        wcommit = avs_write && !s_q.waitreq;
        if (avs_address == CTRL1_OFS) begin
            rd = c1;
        end else if (avs_address == CTRL2_OFS) begin
            rd = c2;
        end else if (avs_address == CTRL3_OFS) begin
            rd = c3;
        end else if (avs_address == MUX_OFS) begin
            rd = {16'h0000, s_q.input_mux_select};
        end else if (avs_address == STAT_OFS) begin
            rd = st;
        end else if (avs_address[6] && avs_address[1:0] == 2'h0) begin
            rd = {{(32 - DATA_W){1'b0}}, s_q.result_buffer[avs_address[5:2]]};
        end
        if (avs_read && s_q.waitreq) begin
            s_d.rdata = rd;
        end
        if (wcommit) begin
            if (avs_address == CTRL1_OFS) begin
                w = arps_merge(c1, avs_writedata, avs_byteenable);
                s_d.converter_on = w[ON_BIT];
                s_d.trigger_source_select = w[TRIG_LSB+:3];
                s_d.simultaneous_sample_select = w[SIMUL_BIT];
                s_d.auto_sample_enable = w[AUTO_BIT];
                s_d.sample_hold_control = w[SHC_BIT];
                s_d.done = w[DONE_BIT];
                s_d.off = 1'b0;
            end else if (avs_address == CTRL2_OFS) begin
                w = arps_merge(c2, avs_writedata, avs_byteenable);
                s_d.sh_channel_count = w[CHCNT_LSB+:2];
                s_d.conversions_per_interrupt = w[CPI_LSB+:4];
            end else if (avs_address == CTRL3_OFS) begin
                w = arps_merge(c3, avs_writedata, avs_byteenable);
                s_d.auto_sample_clocks = w[ASC_LSB+:5];
                s_d.rc_clock_select = w[RC_BIT];
                s_d.conv_clock_divider = w[DIV_LSB+:6];
            end else if (avs_address == MUX_OFS) begin
                w = arps_merge({16'h0000, s_q.input_mux_select}, avs_writedata,
                               avs_byteenable);
                s_d.input_mux_select = w[15:0];
            end else if (avs_address == STAT_OFS) begin
                if (avs_writedata[IRQ_BIT] && avs_byteenable[0]) begin
                    s_d.irq_flag = 1'b0;
                end
            end
        end

        // synchronisers for the pins
        s_d.data_s1 = adc_data;
        s_d.data_s2 = s_q.data_s1;
        s_d.rc_s = {s_q.rc_s[1:0], rc_osc};
        s_d.sleep_d = sleep_mode;

        // conversion clock: divider on core_clk, or the rc oscillator
        if (s_q.rc_clock_select) begin
            tad_tick = s_q.rc_s[1] && !s_q.rc_s[2];
            s_d.tad_cnt = 6'h00;
        end else if (sleep_mode) begin
            tad_tick = 1'b0;
            s_d.tad_cnt = 6'h00;
        end else begin
            tad_tick = (s_q.tad_cnt == s_q.conv_clock_divider);
            s_d.tad_cnt = tad_tick ? 6'h00 : s_q.tad_cnt + 6'h01;
        end

        // one instruction cycle of quiet after sleep entry on rc
        if (sleep_mode && !s_q.sleep_d && s_q.rc_clock_select) begin
            s_d.rc_wait = 2'(INSTR_CLKS);
        end else if (s_q.rc_wait != 2'h0) begin
            s_d.rc_wait = s_q.rc_wait - 2'h1;
        end

        active = s_q.converter_on && !s_q.off;
        samc_eff = (s_q.auto_sample_clocks == 5'h00) ? 5'h01 : s_q.auto_sample_clocks;
        last = arps_last(s_q.sh_channel_count);
        conv_trig = 1'b0;
        conv_end = 1'b0;
        s_d.wake = 1'b0;
        s_d.irq = 1'b0;
        s_d.start = 1'b0;

        if (!active || (sleep_mode && !s_q.rc_clock_select)) begin
            s_d.phase = ARPS_IDLE;
            s_d.hold = 4'h0;
            s_d.trig_pend = 1'b0;
            s_d.conv_tads = 4'h0;
            s_d.sample_tads = 5'h00;
        end else begin
            case (s_q.phase)
                ARPS_IDLE: begin
                    if (s_d.sample_hold_control || s_q.auto_sample_enable) begin
                        s_d.phase = ARPS_SAMPLE;
                        s_d.sample_hold_control = 1'b1;
                        s_d.sample_tads = 5'h00;
                        s_d.trig_pend = 1'b0;
                    end
                end
                ARPS_SAMPLE: begin
                    if (tad_tick && s_q.sample_tads != 5'h1f) begin
                        s_d.sample_tads = s_q.sample_tads + 5'h01;
                    end
                    if (s_q.trigger_source_select == TRIG_AUTO) begin
                        conv_trig = tad_tick && ({1'b0, s_q.sample_tads} + 6'h01
                                    >= {1'b0, samc_eff});
                    end else begin
                        if ((s_q.trigger_source_select == TRIG_MANUAL)
                                ? !s_d.sample_hold_control : ext_trigger) begin
                            s_d.trig_pend = 1'b1;
                        end
                        conv_trig = s_q.trig_pend &&
                                    s_q.sample_tads >= 5'(MIN_SAMPLE_TADS);
                    end
                    if (s_q.rc_wait != 2'h0) begin
                        conv_trig = 1'b0;
                    end
                    if (conv_trig) begin
                        s_d.phase = ARPS_CONVERT;
                        s_d.conv_tads = 4'h0;
                        s_d.trig_pend = 1'b0;
                        s_d.sample_hold_control = 1'b0;
                        s_d.start = 1'b1;
                        s_d.hold = s_q.simultaneous_sample_select
                                   ? arps_mask(s_q.sh_channel_count)
                                   : 4'(4'h1 << s_q.chan);
                    end
                end
                ARPS_CONVERT: begin
                    if (tad_tick) begin
                        s_d.conv_tads = s_q.conv_tads + 4'h1;
                        conv_end = (s_q.conv_tads == 4'(CONV_TADS - 1));
                    end
                    if (conv_end) begin
                        s_d.result_buffer[s_q.wr_idx] = s_q.data_s2;
                        s_d.done = 1'b1;
                        s_d.hold[s_q.chan] = 1'b0;
                        if (s_q.conv_cnt == s_q.conversions_per_interrupt) begin
                            s_d.conv_cnt = 4'h0;
                            s_d.wr_idx = 4'h0;
                            s_d.irq = 1'b1;
                            s_d.irq_flag = 1'b1;
                        end else begin
                            s_d.conv_cnt = s_q.conv_cnt + 4'h1;
                            s_d.wr_idx = s_q.wr_idx + 4'h1;
                        end
                        if (sleep_mode) begin
                            if (int_enable) begin
                                s_d.wake = 1'b1;
                            end else begin
                                s_d.off = 1'b1;
                            end
                        end
                        s_d.chan = (s_q.chan == last) ? 2'h0 : s_q.chan + 2'h1;
                        if (s_q.simultaneous_sample_select && s_q.chan != last) begin
                            s_d.conv_tads = 4'h0;
                            s_d.start = 1'b1;
                        end else if (s_q.auto_sample_enable && !(sleep_mode && !int_enable)) begin
                            s_d.phase = ARPS_SAMPLE;
                            s_d.sample_hold_control = 1'b1;
                            s_d.sample_tads = 5'h00;
                        end else begin
                            s_d.phase = ARPS_IDLE;
                        end
                    end
                end
                default: begin
                    s_d.phase = ARPS_IDLE;
                end
            endcase
        end
        if (s_q.chan > arps_last(s_q.sh_channel_count)) begin
            s_d.chan = 2'h0;
        end
        s_d.power = s_d.converter_on && !s_d.off;
        s_d.sample_out = (s_d.power && s_d.phase != ARPS_IDLE)
                         ? arps_mask(s_d.sh_channel_count) & ~s_d.hold : 4'h0;
    end

    // ------------------------------------------------------------
    // register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.waitreq <= 1'b1;
            s_q.phase <= ARPS_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata = s_q.rdata;
    assign avs_waitrequest = s_q.waitreq;
    assign wake_req = s_q.wake;
    assign conv_irq = s_q.irq;
    assign sh_sample = s_q.sample_out;
    assign conv_start = s_q.start;
    assign analog_power = s_q.power;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking arps_cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    logic [4:0] samc_eff_chk;
    assign samc_eff_chk = (s_q.auto_sample_clocks == 5'h00) ? 5'h01 : s_q.auto_sample_clocks;

    a_off_idle: assert property (!s_q.converter_on |=> s_q.phase == ARPS_IDLE
        && sh_sample == 4'h0 && (!analog_power || s_q.converter_on))
        else $error("off converter not idle");
    a_sleep_noclk: assert property (sleep_mode && !s_q.rc_clock_select |-> !tad_tick)
        else $error("conversion clock ran in sleep");
    a_sleep_abort: assert property (sleep_mode && !s_q.rc_clock_select
        && s_q.phase == ARPS_CONVERT |=> s_q.phase == ARPS_IDLE && !conv_end)
        else $error("sleep did not abort conversion");
    a_cfg_kept: assert property ((sleep_mode != s_q.sleep_d) && !avs_write
        |=> $stable(s_q.conv_clock_divider) && $stable(s_q.trigger_source_select)
        && $stable(s_q.sh_channel_count)) else $error("sleep changed registers");
    a_rc_quiet: assert property (sleep_mode && !s_q.sleep_d && s_q.rc_clock_select
        |=> !conv_trig ##1 !conv_trig) else $error("rc conversion started too early");
    a_conv_len: assert property (conv_end |-> tad_tick
        && s_q.conv_tads == 4'hb && s_q.phase == ARPS_CONVERT) else $error("bad length");
    a_auto_end: assert property (conv_trig && s_q.trigger_source_select == TRIG_AUTO
        |-> tad_tick && {1'b0, s_q.sample_tads} + 6'h01 >= {1'b0, samc_eff_chk})
        else $error("auto trigger at wrong clock");
    a_done_load: assert property (conv_end |=> s_q.done
        && s_q.result_buffer[$past(s_q.wr_idx)] == $past(s_q.data_s2))
        else $error("result not stored");
    a_wake_req: assert property (conv_end && sleep_mode && int_enable |=> wake_req)
        else $error("no wake on completion");
    a_off_sleep: assert property (conv_end && sleep_mode && !int_enable
        |=> s_q.off && s_q.converter_on && !analog_power) else $error("not turned off");
    a_min_sample: assert property (conv_trig |-> s_q.sample_tads != 5'h00 || tad_tick)
        else $error("sampling shorter than one clock");
    a_one_chan: assert property (s_q.sh_channel_count == 2'h0 |-> s_q.hold[3:1] == 3'h0)
        else $error("extra channel held");
    a_seq_hold: assert property (!s_q.simultaneous_sample_select
        && s_q.phase == ARPS_CONVERT |-> $onehot(s_q.hold)) else $error("sequential hold");

    c_conv_done: cover property (conv_end);
    c_sleep_wake: cover property (conv_end && sleep_mode && int_enable);
    c_seq_multi: cover property (s_q.phase == ARPS_CONVERT && s_q.sh_channel_count != 2'h0
        && !s_q.simultaneous_sample_select);
    c_abort: cover property (s_q.phase == ARPS_CONVERT && !s_q.converter_on);

endmodule : arps_sequencer

// >>> tb/arps_analog_model.sv
`timescale 1ns/1ps
module arps_analog_model (
    // clock
    input wire logic core_clk,
    // converter side
    input wire logic conv_start,
    input wire logic [9:0] base,
    output logic rc_osc,
    output logic [9:0] adc_data
);
    logic [9:0] k_q;
    initial begin
        k_q = 10'h000;
        adc_data = 10'h155;
        rc_osc = 1'b0;
        forever #37 rc_osc = ~rc_osc;
    end
    // ---------------------------------------------
    // a new level per conversion, held while it runs
    // ---------------------------------------------
    always @(posedge core_clk) begin
        if (conv_start === 1'b1) begin
            adc_data <= base + k_q * 10'h025;
            k_q <= k_q + 10'h001;
        end
    end
endmodule : arps_analog_model

// >>> tb/arps_sequencer_bench.sv
`timescale 1ns/1ps
module arps_sequencer_bench;
    import arps_pkg::*;
    logic core_clk, resetn, avs_read, avs_write, avs_waitrequest, sleep_mode, int_enable;
    logic wake_req, conv_irq, conv_start, analog_power, rc_osc, gap_on, slp_chk;
    logic [6:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd, keep;
    logic [3:0] sh_sample;
    logic [9:0] adc_data, base;
    logic [5:0] div;
    int error_cnt, num_checks, seed, cyc, last_t, n;
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    arps_sequencer DUT (.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sleep_mode(sleep_mode),
        .int_enable(int_enable), .ext_trigger(1'b0), .wake_req(wake_req),
        .conv_irq(conv_irq), .rc_osc(rc_osc), .adc_data(adc_data),
        .sh_sample(sh_sample), .conv_start(conv_start), .analog_power(analog_power));
    arps_analog_model model (.core_clk(core_clk), .conv_start(conv_start), .base(base),
        .rc_osc(rc_osc), .adc_data(adc_data));
    task print_verdict;
        $display("errors %0d checks %0d", error_cnt, num_checks);
        if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    task check(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : check
    task bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    function logic [31:0] exp_res(input int k);
        return {22'h0, base + 10'(k * 37)};
    endfunction : exp_res
    // ---------------------------------------------
    // monitor: spacing, channel use, sleep, timeout
    // ---------------------------------------------
    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 30000) begin
            error_cnt++;
            print_verdict();
        end
        if (conv_start === 1'b1) begin
            if (gap_on && last_t > 0) check(32'(cyc - last_t <= 14 * (div + 1) + 3
                && cyc - last_t >= 14 * (div + 1)), 1, "spacing");
            last_t = cyc;
            if (slp_chk) check(0, 1, "conversion in sleep");
        end
        if (gap_on) check(32'(sh_sample[3:1]), 0, "extra channel");
    end
    initial begin
        {avs_read, avs_write, sleep_mode, int_enable, gap_on, slp_chk, resetn} = 0;
        {avs_address, avs_writedata, cyc, last_t, error_cnt, num_checks} = 0;
        seed = 38;
        div = 6'($random(seed)) & 6'h03;
        base = 10'($random(seed));
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        for (n = 0; n < 6; n++) begin
            bus(1'b0, 7'(n * 4), 32'h0);
            check(rd, 32'h0, "reset value");
        end
        bus(1'b1, MUX_OFS, 32'h0000_0000);
        bus(1'b1, CTRL2_OFS, 32'h0000_0004);
        bus(1'b1, CTRL3_OFS, {19'h0, 5'h02, 2'b00, div});
        gap_on = 1'b1;
        bus(1'b1, CTRL1_OFS, 32'h0000_80e4);
        while (conv_irq !== 1'b1) @(posedge core_clk);
        bus(1'b0, BUF_OFS, 32'h0);
        check(rd, exp_res(0), "buffer 0");
        bus(1'b0, BUF_OFS + 7'h04, 32'h0);
        check(rd, exp_res(1), "buffer 1");
        bus(1'b0, CTRL1_OFS, 32'h0);
        check(32'(rd[DONE_BIT]), 1, "done");
        check(32'(analog_power), 1, "power");
        repeat (150) @(posedge core_clk);
        keep = rd;
        gap_on = 1'b0;
        while (conv_start !== 1'b1) @(posedge core_clk);
        sleep_mode <= 1'b1;
        repeat (3) @(posedge core_clk);
        slp_chk = 1'b1;
        repeat (60) @(posedge core_clk);
        check(32'(sh_sample), 0, "sampling in sleep");
        slp_chk = 1'b0;
        sleep_mode <= 1'b0;
        bus(1'b0, CTRL1_OFS, 32'h0);
        check(rd & 32'hffff_fffc, keep & 32'hffff_fffc, "ctrl1 kept");
        bus(1'b1, CTRL3_OFS, {19'h0, 5'h02, 2'b10, div});
        int_enable <= 1'b1;
        sleep_mode <= 1'b1;
        for (n = 0; n < 3000 && wake_req !== 1'b1; n++) @(posedge core_clk);
        check(32'(n < 3000), 1, "no wake");
        int_enable <= 1'b0;
        n = 0;
        do begin
            bus(1'b0, STAT_OFS, 32'h0);
            n++;
        end while (rd[OFF_BIT] !== 1'b1 && n < 500);
        check(32'(rd[OFF_BIT]), 1, "not off");
        check(32'(analog_power), 0, "still powered");
        sleep_mode <= 1'b0;
        bus(1'b0, CTRL1_OFS, 32'h0);
        check(32'(rd[ON_BIT]), 1, "on bit lost");
        bus(1'b1, CTRL1_OFS, 32'h0);
        repeat (2) @(posedge core_clk);
        check(32'(analog_power), 0, "power after off");
        bus(1'b1, CTRL1_OFS, 32'h0000_8000);
        repeat (20) @(posedge core_clk);
        check(32'(analog_power), 1, "power after on");
        print_verdict();
    end
endmodule : arps_sequencer_bench
